//--- logic/blk_cmd_pkg.sv
// constants and carrier types for the block command decoder
// How it works
// - first byte 2a in a ten-byte command decodes as a block write.
// - bytes 2-5 start address msb first, 7-8 count, byte 9 control zero.
// - write without forced media access may complete from cache.
// - media error after cached good status is held and reported later.
// - forced media access write waits for every block on the medium.
// - zero write count moves nothing and completes good.
// - first byte 2f decodes as verify with same layout.
// - verify checks count consecutive blocks from the start address.
// - zero verify count checks nothing and is not an error.
// - parameter page byte 0 is savable bit plus code 06, byte 1 is 08.
// - changeable page fields are written by the host and kept as saved.
// - cache enabled lets write status go good after data received.
// - cache disabled holds write status until data is on the medium.
// - page bytes 3-4 give block size msb first.
// - page bytes 5-9 hold changeable block count msb first.
// - default request returns factory count, saved request returns saved count.
// - inquiry, mode select, mode sense, test ready, write buffer accepted.
// - inquiry passes through in full to the handler.
// - page value select 10 gives defaults, 11 gives saved values.
package blk_cmd_pkg;
  localparam logic [7:0] OP_WRITE = 8'h2a;
  localparam logic [7:0] OP_VERIFY = 8'h2f;
  localparam logic [7:0] OP_INQUIRY = 8'h12;
  localparam logic [7:0] OP_MSELECT = 8'h55;
  localparam logic [7:0] OP_MSENSE = 8'h5a;
  localparam logic [7:0] OP_TUR = 8'h00;
  localparam logic [7:0] OP_WBUF = 8'h3b;
  localparam logic [5:0] PAGE_CODE = 6'h06;
  localparam logic [7:0] PAGE_LEN = 8'h08;
  localparam logic [1:0] PVS_DEFAULT = 2'h2;
  localparam logic [1:0] PVS_SAVED = 2'h3;
  localparam int CDB_BYTES = 10;
  localparam int PAGE_BYTES = 10;
  localparam int FORCE_ACCESS_BIT = 3;
  localparam logic [7:0] ST_GOOD = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [3:0] SK_MEDIUM = 4'h3;
  localparam logic [7:0] ASC_BAD_OP = 8'h20;
  localparam logic [7:0] ASC_WRITE_ERR = 8'h0c;
  localparam logic [15:0] BLK_SIZE_RST = 16'h0200;
  localparam logic [39:0] NBLK_RST = 40'h0000100000;
  localparam logic WCO_RST = 1'b0;
  typedef enum logic [3:0] {
    CK_NONE = 4'h0, CK_WRITE = 4'h1, CK_VERIFY = 4'h2, CK_INQUIRY = 4'h3,
    CK_MSELECT = 4'h4, CK_MSENSE = 4'h5, CK_TUR = 4'h6, CK_WBUF = 4'h7,
    CK_BAD = 4'h8
  } cmd_kind_t;
  typedef struct packed {
    cmd_kind_t kind;
    logic [31:0] lba;
    logic [15:0] count;
    logic force_media_access;
    logic [1:0] page_value_select;
    logic ctl_bad;
  } cmd_t;
  typedef struct packed {
    logic [7:0] status;
    logic [3:0] sense_key;
    logic [7:0] asc;
    logic deferred;
  } resp_t;
endpackage

//--- logic/cdb_decode.sv
// combinational decode of a ten-byte command block
`timescale 1ns/1ns
module cdb_decode (
  // command bytes, byte 0 in the low lane
  input wire logic [79:0] cdb,
  // decoded fields
  output blk_cmd_pkg::cmd_t cmd
);
  function automatic logic [7:0] by(input logic [79:0] c, input int i);
    by = c[i*8 +: 8];
  endfunction
  always_comb begin
    cmd = '0;
    case (by(cdb, 0))
      blk_cmd_pkg::OP_WRITE: cmd.kind = blk_cmd_pkg::CK_WRITE;
      blk_cmd_pkg::OP_VERIFY: cmd.kind = blk_cmd_pkg::CK_VERIFY;
      blk_cmd_pkg::OP_INQUIRY: cmd.kind = blk_cmd_pkg::CK_INQUIRY;
      blk_cmd_pkg::OP_MSELECT: cmd.kind = blk_cmd_pkg::CK_MSELECT;
      blk_cmd_pkg::OP_MSENSE: cmd.kind = blk_cmd_pkg::CK_MSENSE;
      blk_cmd_pkg::OP_TUR: cmd.kind = blk_cmd_pkg::CK_TUR;
      blk_cmd_pkg::OP_WBUF: cmd.kind = blk_cmd_pkg::CK_WBUF;
      default: cmd.kind = blk_cmd_pkg::CK_BAD;
    endcase
    cmd.lba = {by(cdb, 2), by(cdb, 3), by(cdb, 4), by(cdb, 5)};
    cmd.count = {by(cdb, 7), by(cdb, 8)};
    cmd.force_media_access = cdb[8 + blk_cmd_pkg::FORCE_ACCESS_BIT];
    cmd.page_value_select = cdb[23:22];
    cmd.ctl_bad = (by(cdb, 9) != 8'h00);
  end
endmodule // cdb_decode

//--- logic/blk_cmd_ctrl.sv
// block command interpreter: dispatch, write/verify sequencing, parameter page
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
module blk_cmd_ctrl (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // command in
  input wire logic CMD_VALID,
  input wire logic [79:0] CMD_CDB,
  output logic CMD_READY,
  // per-block media/cache operations
  output logic BLK_REQ,
  output logic [31:0] BLK_LBA,
  output logic BLK_VERIFY,
  output logic BLK_TO_MEDIA,
  input wire logic BLK_DATA_IN,
  input wire logic BLK_ON_MEDIA,
  input wire logic BLK_ERR,
  // late error from cache flush
  input wire logic FLUSH_ERR,
  // common command hand-off
  output logic COMMON_REQ,
  output logic [79:0] COMMON_CDB,
  input wire logic COMMON_DONE,
  input wire logic COMMON_FAIL,
  // parameter page access
  input wire logic PAGE_WR,
  input wire logic [3:0] PAGE_IDX,
  input wire logic [7:0] PAGE_WDATA,
  input wire logic [3:0] PAGE_RIDX,
  output logic [7:0] PAGE_RDATA,
  output logic WRITE_CACHE_OFF,
  // completion
  output logic DONE,
  output blk_cmd_pkg::resp_t RESP
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_BLK = 5'b00010, S_WAIT = 5'b00100,
    S_COMMON = 5'b01000, S_END = 5'b10000
  } state_t;

  blk_cmd_pkg::cmd_t dec;
  blk_cmd_pkg::cmd_t cur_ff;
  state_t state_ff;
  logic [15:0] left_ff;
  logic [31:0] lba_ff;
  logic media_ff;
  logic err_ff;
  logic defer_ff;
  logic [7:0] sense_ff;
  logic write_cache_off_ff;
  logic [15:0] blk_size_ff;
  logic [39:0] nblk_ff;
  logic [79:0] common_cdb_ff;
  logic [1:0] pvs_ff;
  logic blk_req_ff;
  logic done_ff;
  blk_cmd_pkg::resp_t resp_ff;
  logic [7:0] page_rdata_ff;
  logic take;
  logic blk_ack;
  logic ctl_reject;

  cdb_decode u_dec (
    .cdb(CMD_CDB),
    .cmd(dec)
  );

  assign CMD_READY = (state_ff == S_IDLE);
  assign take = CMD_VALID && CMD_READY;
  assign ctl_reject = dec.ctl_bad || dec.kind == blk_cmd_pkg::CK_BAD;
  // cached path acknowledges on receipt, media path on recording
  assign blk_ack = media_ff ? BLK_ON_MEDIA : BLK_DATA_IN;

  // command sequencing
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      state_ff <= S_IDLE;
      cur_ff <= '0;
      left_ff <= 16'h0000;
      lba_ff <= 32'h00000000;
      media_ff <= 1'b0;
      err_ff <= 1'b0;
      blk_req_ff <= 1'b0;
      common_cdb_ff <= 80'h0;
    end else begin
      case (state_ff)
        S_IDLE: begin
          err_ff <= 1'b0;
          if (take) begin
            cur_ff <= dec;
            lba_ff <= dec.lba;
            left_ff <= dec.count;
            // cache disabled or forced access both demand the medium
            media_ff <= dec.force_media_access || write_cache_off_ff;
            common_cdb_ff <= CMD_CDB;
            if (ctl_reject)
              state_ff <= S_END;
            else if (dec.kind == blk_cmd_pkg::CK_WRITE ||
                     dec.kind == blk_cmd_pkg::CK_VERIFY)
              state_ff <= (dec.count == 16'h0000) ? S_END : S_BLK;
            else if (dec.kind == blk_cmd_pkg::CK_MSELECT ||
                     dec.kind == blk_cmd_pkg::CK_MSENSE)
              state_ff <= S_END;
            else
              state_ff <= S_COMMON;
          end
        end
        S_BLK: begin
          blk_req_ff <= 1'b1;
          state_ff <= S_WAIT;
        end
        S_WAIT: begin
          if (BLK_ERR) begin
            blk_req_ff <= 1'b0;
            err_ff <= 1'b1;
            state_ff <= S_END;
          end else if (cur_ff.kind == blk_cmd_pkg::CK_VERIFY ? BLK_ON_MEDIA : blk_ack) begin
            blk_req_ff <= 1'b0;
            lba_ff <= lba_ff + 32'h1;
            left_ff <= left_ff - 16'h1;
            state_ff <= (left_ff == 16'h0001) ? S_END : S_BLK;
          end
        end
        S_COMMON: begin
          if (COMMON_DONE) begin
            err_ff <= COMMON_FAIL;
            state_ff <= S_END;
          end
        end
        S_END: state_ff <= S_IDLE;
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // deferred error: set wins over the report that clears it
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B)
      defer_ff <= 1'b0;
    else if (FLUSH_ERR)
      defer_ff <= 1'b1;
    else if (state_ff == S_END && cur_ff.kind != blk_cmd_pkg::CK_BAD && !cur_ff.ctl_bad)
      defer_ff <= 1'b0;
  end

  // completion status
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      done_ff <= 1'b0;
      resp_ff <= '0;
    end else begin
      done_ff <= (state_ff == S_END);
      if (state_ff == S_END) begin
        resp_ff <= '0;
        if (cur_ff.kind == blk_cmd_pkg::CK_BAD || cur_ff.ctl_bad) begin
          resp_ff.status <= blk_cmd_pkg::ST_CHECK;
          resp_ff.sense_key <= blk_cmd_pkg::SK_ILLEGAL;
          resp_ff.asc <= blk_cmd_pkg::ASC_BAD_OP;
        end else if (defer_ff) begin
          resp_ff.status <= blk_cmd_pkg::ST_CHECK;
          resp_ff.sense_key <= blk_cmd_pkg::SK_MEDIUM;
          resp_ff.asc <= blk_cmd_pkg::ASC_WRITE_ERR;
          resp_ff.deferred <= 1'b1;
        end else if (err_ff) begin
          resp_ff.status <= blk_cmd_pkg::ST_CHECK;
          resp_ff.sense_key <= blk_cmd_pkg::SK_MEDIUM;
          resp_ff.asc <= blk_cmd_pkg::ASC_WRITE_ERR;
        end else begin
          resp_ff.status <= blk_cmd_pkg::ST_GOOD;
        end
      end
    end
  end

  // changeable page fields, saved across commands
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      write_cache_off_ff <= blk_cmd_pkg::WCO_RST;
      nblk_ff <= blk_cmd_pkg::NBLK_RST;
      blk_size_ff <= blk_cmd_pkg::BLK_SIZE_RST;
    end else if (PAGE_WR && state_ff == S_IDLE) begin
      // only the changeable fields take writes; the rest stay fixed
      case (PAGE_IDX)
        4'h2: write_cache_off_ff <= PAGE_WDATA[0];
        4'h5: nblk_ff[39:32] <= PAGE_WDATA;
        4'h6: nblk_ff[31:24] <= PAGE_WDATA;
        4'h7: nblk_ff[23:16] <= PAGE_WDATA;
        4'h8: nblk_ff[15:8] <= PAGE_WDATA;
        4'h9: nblk_ff[7:0] <= PAGE_WDATA;
        default: ;
      endcase
    end
  end

  // page value select latched from the last mode sense
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B)
      pvs_ff <= blk_cmd_pkg::PVS_SAVED;
    else if (take && dec.kind == blk_cmd_pkg::CK_MSENSE)
      pvs_ff <= dec.page_value_select;
  end

  // page readback, defaults use factory values
  logic [39:0] nb;
  logic wc;
  assign nb = (pvs_ff == blk_cmd_pkg::PVS_DEFAULT) ? blk_cmd_pkg::NBLK_RST : nblk_ff;
  assign wc = (pvs_ff == blk_cmd_pkg::PVS_DEFAULT) ? blk_cmd_pkg::WCO_RST : write_cache_off_ff;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      page_rdata_ff <= 8'h00;
    end else begin
      case (PAGE_RIDX)
        4'h0: page_rdata_ff <= {1'b1, 1'b0, blk_cmd_pkg::PAGE_CODE};
        4'h1: page_rdata_ff <= blk_cmd_pkg::PAGE_LEN;
        4'h2: page_rdata_ff <= {7'h00, wc};
        4'h3: page_rdata_ff <= blk_size_ff[15:8];
        4'h4: page_rdata_ff <= blk_size_ff[7:0];
        4'h5: page_rdata_ff <= nb[39:32];
        4'h6: page_rdata_ff <= nb[31:24];
        4'h7: page_rdata_ff <= nb[23:16];
        4'h8: page_rdata_ff <= nb[15:8];
        4'h9: page_rdata_ff <= nb[7:0];
        default: page_rdata_ff <= 8'h00;
      endcase
    end
  end

  assign BLK_REQ = blk_req_ff;
  assign BLK_LBA = lba_ff;
  assign BLK_VERIFY = (cur_ff.kind == blk_cmd_pkg::CK_VERIFY);
  assign BLK_TO_MEDIA = media_ff;
  assign COMMON_REQ = (state_ff == S_COMMON);
  assign COMMON_CDB = common_cdb_ff;
  assign PAGE_RDATA = page_rdata_ff;
  assign WRITE_CACHE_OFF = write_cache_off_ff;
  assign DONE = done_ff;
  assign RESP = resp_ff;

  AST_ZERO_COUNT_GOOD: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    take && !ctl_reject && (dec.kind == blk_cmd_pkg::CK_WRITE) && dec.count == 16'h0 &&
    !defer_ff && !FLUSH_ERR |-> ##2 DONE && RESP.status == blk_cmd_pkg::ST_GOOD && !BLK_REQ)
    else $error("zero length write not good");
  AST_ZERO_VERIFY: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    take && !ctl_reject && dec.kind == blk_cmd_pkg::CK_VERIFY && dec.count == 16'h0
    |-> ##1 state_ff == S_END ##1 !BLK_REQ)
    else $error("zero verify touched media");
  AST_BAD_OP: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    take && dec.kind == blk_cmd_pkg::CK_BAD |-> ##2 DONE &&
    RESP.status == blk_cmd_pkg::ST_CHECK && RESP.sense_key == blk_cmd_pkg::SK_ILLEGAL)
    else $error("unknown opcode not rejected");
  AST_MEDIA_WAIT: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    state_ff == S_WAIT && media_ff && !BLK_ON_MEDIA && !BLK_ERR |=> state_ff == S_WAIT)
    else $error("media write advanced before recorded");
  AST_CACHE_ACK: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    state_ff == S_WAIT && !media_ff && !BLK_VERIFY && BLK_DATA_IN && !BLK_ERR
    |=> state_ff != S_WAIT)
    else $error("cached write did not advance on receipt");
  AST_LBA_STEP: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    state_ff == S_WAIT && BLK_VERIFY && BLK_ON_MEDIA && !BLK_ERR
    |=> BLK_LBA == $past(BLK_LBA) + 32'h1)
    else $error("verify address did not step");
  AST_DEFER_HELD: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    FLUSH_ERR |=> defer_ff)
    else $error("deferred error lost");
  AST_PAGE_HDR: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    PAGE_RIDX == 4'h0 |=> PAGE_RDATA == 8'h86)
    else $error("page header byte wrong");
  AST_DEFAULT_NBLK: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    pvs_ff == blk_cmd_pkg::PVS_DEFAULT && PAGE_RIDX == 4'h9 && !PAGE_WR
    |=> PAGE_RDATA == blk_cmd_pkg::NBLK_RST[7:0])
    else $error("default block count not factory value");
  AST_REQ_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    BLK_REQ && !BLK_ERR && !BLK_ON_MEDIA && !BLK_DATA_IN |=> BLK_REQ)
    else $error("block request dropped without an answer");
  AST_COMMON_END: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    COMMON_REQ && COMMON_DONE |-> ##2 DONE)
    else $error("common command did not complete");
endmodule // blk_cmd_ctrl

//--- tb/media_model.sv
// media, cache and common-command handler on the far side of the interpreter
`timescale 1ns/1ns
module media_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // block operations
  input wire logic blk_req,
  input wire logic [31:0] blk_lba,
  input wire logic blk_verify,
  input wire logic blk_to_media,
  output logic blk_data_in,
  output logic blk_on_media,
  output logic blk_err,
  // common command hand-off
  input wire logic common_req,
  output logic common_done,
  output logic common_fail,
  // bench controls and tallies
  input wire logic fail_blk,
  input wire logic [3:0] lag,
  output int nblk,
  output int nmed,
  output logic [31:0] last_lba
);
  logic [3:0] wait_ff;
  logic acked_ff;
  logic cacked_ff;
  // one answer per request; the request is still high in the cycle after it
  always_ff @(posedge clk) begin
    blk_data_in <= 1'b0;
    blk_on_media <= 1'b0;
    blk_err <= 1'b0;
    if (!rst_b || !blk_req) begin
      wait_ff <= 4'h0;
      acked_ff <= 1'b0;
    end else if (!acked_ff && wait_ff < lag) begin
      wait_ff <= wait_ff + 4'h1;
    end else if (!acked_ff) begin
      acked_ff <= 1'b1;
      nblk <= nblk + 1;
      last_lba <= blk_lba;
      if (fail_blk) begin
        blk_err <= 1'b1;
      end else if (blk_verify || blk_to_media) begin
        blk_on_media <= 1'b1;
        nmed <= nmed + 1;
      end else begin
        blk_data_in <= 1'b1;
      end
    end
  end
  // fail line toggles outside the answer so a stale level is never trusted;
  // at the answer it follows the bench's failure control
  always_ff @(posedge clk) begin
    common_done <= 1'b0;
    common_fail <= rst_b & ~common_fail;
    if (!rst_b || !common_req) begin
      cacked_ff <= 1'b0;
    end else if (!cacked_ff) begin
      cacked_ff <= 1'b1;
      common_done <= 1'b1;
      common_fail <= fail_blk;
    end
  end
endmodule // media_model

//--- tb/block_write_verify_cmd_decoder_tb.sv
// self-checking bench for the block command interpreter
`timescale 1ns/1ns
module block_write_verify_cmd_decoder_tb;
  localparam logic [20:0] GOOD = 21'h000000;
  localparam logic [20:0] BAD = {blk_cmd_pkg::ST_CHECK, blk_cmd_pkg::SK_ILLEGAL,
    blk_cmd_pkg::ASC_BAD_OP, 1'b0};
  localparam logic [20:0] DEF = {blk_cmd_pkg::ST_CHECK, blk_cmd_pkg::SK_MEDIUM,
    blk_cmd_pkg::ASC_WRITE_ERR, 1'b1};
  localparam logic [20:0] MED = {blk_cmd_pkg::ST_CHECK, blk_cmd_pkg::SK_MEDIUM,
    blk_cmd_pkg::ASC_WRITE_ERR, 1'b0};
  logic clk, rst_b, valid, ready, breq, bver, bmed, din, onm, berr, ferr;
  logic creq, cdone, cfail, pwr, done, wco, fail_blk;
  logic [79:0] cdb, ccdb;
  logic [31:0] blba, last_lba;
  logic [3:0] pidx, pridx, lag;
  logic [7:0] pwd, prd;
  logic [7:0] ops [5];
  blk_cmd_pkg::resp_t resp;
  int nblk, nmed, failures, comparisons, i;

  blk_cmd_ctrl i_dut (.CLK_SYS(clk), .RST_B(rst_b), .CMD_VALID(valid), .CMD_CDB(cdb),
    .CMD_READY(ready), .BLK_REQ(breq), .BLK_LBA(blba), .BLK_VERIFY(bver),
    .BLK_TO_MEDIA(bmed), .BLK_DATA_IN(din), .BLK_ON_MEDIA(onm), .BLK_ERR(berr),
    .FLUSH_ERR(ferr), .COMMON_REQ(creq), .COMMON_CDB(ccdb), .COMMON_DONE(cdone),
    .COMMON_FAIL(cfail), .PAGE_WR(pwr), .PAGE_IDX(pidx), .PAGE_WDATA(pwd),
    .PAGE_RIDX(pridx), .PAGE_RDATA(prd), .WRITE_CACHE_OFF(wco), .DONE(done), .RESP(resp));
  media_model i_media (.clk(clk), .rst_b(rst_b), .blk_req(breq), .blk_lba(blba),
    .blk_verify(bver), .blk_to_media(bmed), .blk_data_in(din), .blk_on_media(onm),
    .blk_err(berr), .common_req(creq), .common_done(cdone), .common_fail(cfail),
    .fail_blk(fail_blk), .lag(lag), .nblk(nblk), .nmed(nmed), .last_lba(last_lba));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [79:0] mk(input logic [7:0] op, input logic [7:0] b1,
      input logic [31:0] lba, input logic [15:0] n, input logic [7:0] ctl);
    mk = {ctl, n[7:0], n[15:8], 8'h00, lba[7:0], lba[15:8], lba[23:16], lba[31:24], b1, op};
  endfunction

  // ready is high whenever idle, so the edge after the offer takes it
  task automatic run(input logic [79:0] c);
    int k;
    @(posedge clk);
    valid <= 1'b1;
    cdb <= c;
    @(posedge clk);
    valid <= 1'b0;
    for (k = 0; k < 300 && done !== 1'b1; k++) @(posedge clk);
    if (k == 300) begin
      failures++;
      conclude();
    end
  endtask

  task automatic xfer(input logic [79:0] c, input int en, input int em,
      input logic [31:0] el, input logic [20:0] er);
    int n0;
    int m0;
    n0 = nblk;
    m0 = nmed;
    run(c);
    chk(resp, er);
    chk(nblk - n0, en);
    chk(nmed - m0, em);
    if (en > 0) chk(last_lba, el);
  endtask

  task automatic pw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    pwr <= 1'b1;
    pidx <= a;
    pwd <= d;
    @(posedge clk);
    pwr <= 1'b0;
  endtask

  task automatic pr(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    pridx <= a;
    repeat (2) @(posedge clk);
    chk(prd, e);
  endtask

  initial begin
    rst_b = 1'b0;
    valid = 1'b0;
    cdb = 80'h0;
    ferr = 1'b0;
    pwr = 1'b0;
    pidx = 4'h0;
    pwd = 8'h00;
    pridx = 4'h0;
    lag = 4'h0;
    fail_blk = 1'b0;
    ops = '{blk_cmd_pkg::OP_INQUIRY, blk_cmd_pkg::OP_MSELECT, blk_cmd_pkg::OP_MSENSE,
      blk_cmd_pkg::OP_TUR, blk_cmd_pkg::OP_WBUF};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    pr(4'h0, {2'b10, blk_cmd_pkg::PAGE_CODE});
    pr(4'h1, blk_cmd_pkg::PAGE_LEN);
    pr(4'h3, blk_cmd_pkg::BLK_SIZE_RST[15:8]);
    pr(4'h4, blk_cmd_pkg::BLK_SIZE_RST[7:0]);
    for (i = 5; i < 10; i++) pr(i[3:0], blk_cmd_pkg::NBLK_RST[8*(9-i) +: 8]);
    $display("test page reset done");
    xfer(mk(8'h2a, 8'h00, 32'h01020304, 16'h0003, 8'h00), 3, 0, 32'h01020306, GOOD);
    @(posedge clk);
    ferr <= 1'b1;
    @(posedge clk);
    ferr <= 1'b0;
    xfer(mk(8'h00, 8'h00, 32'h0, 16'h0, 8'h00), 0, 0, 32'h0, DEF);
    xfer(mk(8'h00, 8'h00, 32'h0, 16'h0, 8'h00), 0, 0, 32'h0, GOOD);
    lag <= 4'h5;
    xfer(mk(8'h2a, 8'h08, 32'h00000100, 16'h0002, 8'h00), 2, 2, 32'h00000101, GOOD);
    xfer(mk(8'h2a, 8'h00, 32'h00000050, 16'h0000, 8'h00), 0, 0, 32'h0, GOOD);
    xfer(mk(8'h2f, 8'h00, 32'h00000010, 16'h0004, 8'h00), 4, 4, 32'h00000013, GOOD);
    xfer(mk(8'h2f, 8'h00, 32'h00000010, 16'h0000, 8'h00), 0, 0, 32'h0, GOOD);
    $display("test write verify done");
    pw(4'h2, 8'h01);
    pr(4'h2, 8'h01);
    chk(wco, 1'b1);
    xfer(mk(8'h2a, 8'h00, 32'h00000020, 16'h0001, 8'h00), 1, 1, 32'h00000020, GOOD);
    pw(4'h2, 8'h00);
    xfer(mk(8'h2a, 8'h00, 32'h00000021, 16'h0001, 8'h00), 1, 0, 32'h00000021, GOOD);
    fail_blk <= 1'b1;
    xfer(mk(8'h2a, 8'h08, 32'h00000030, 16'h0002, 8'h00), 1, 0, 32'h00000030, MED);
    xfer(mk(blk_cmd_pkg::OP_TUR, 8'h00, 32'h0, 16'h0, 8'h00), 0, 0, 32'h0, MED);
    fail_blk <= 1'b0;
    $display("test cache and error done");
    xfer(mk(8'h28, 8'h00, 32'h0, 16'h0001, 8'h00), 0, 0, 32'h0, BAD);
    xfer(mk(8'h2a, 8'h00, 32'h0, 16'h0001, 8'h01), 0, 0, 32'h0, BAD);
    $display("test refusal done");
    for (i = 5; i < 10; i++) pw(i[3:0], 8'(i + 16));
    xfer(mk(blk_cmd_pkg::OP_MSENSE, 8'h08, 32'hc0000000, 16'h0, 8'h00), 0, 0, 32'h0, GOOD);
    for (i = 5; i < 10; i++) pr(i[3:0], 8'(i + 16));
    xfer(mk(blk_cmd_pkg::OP_MSENSE, 8'h08, 32'h80000000, 16'h0, 8'h00), 0, 0, 32'h0, GOOD);
    for (i = 5; i < 10; i++) pr(i[3:0], blk_cmd_pkg::NBLK_RST[8*(9-i) +: 8]);
    $display("test page values done");
    for (i = 0; i < 5; i++) xfer(mk(ops[i], 8'h01, 32'h0, 16'h0, 8'h00), 0, 0, 32'h0, GOOD);
    run(mk(blk_cmd_pkg::OP_INQUIRY, 8'h01, 32'ha5c3e1f0, 16'h5aff, 8'h00));
    chk(ccdb, mk(blk_cmd_pkg::OP_INQUIRY, 8'h01, 32'ha5c3e1f0, 16'h5aff, 8'h00));
    $display("test common commands done");
    conclude();
  end
endmodule // block_write_verify_cmd_decoder_tb
